// ### rtl/adc_pkg.sv
// Package: register map, field positions, reset values and codes of the audio decoder control bank
package adc_pkg;
  localparam logic [6:0] ADC_DEV_ADDR      = 7'h43;        // Bus device address (1000011)
  localparam logic [7:0] ADC_OFS_VERSION   = 8'h00;        // Chip version
  localparam logic [7:0] ADC_OFS_IDENT     = 8'h01;        // Chip identifier
  localparam logic [7:0] ADC_OFS_CLKCTL    = 8'h05;        // Clock generator control
  localparam logic [7:0] ADC_OFS_PLLM      = 8'h06;        // Multiplier
  localparam logic [7:0] ADC_OFS_PLLN      = 8'h07;        // Input divider
  localparam logic [7:0] ADC_OFS_REQPOL    = 8'h0C;        // Request line polarity
  localparam logic [7:0] ADC_OFS_CLKPOL    = 8'h0D;        // Input clock polarity
  localparam logic [7:0] ADC_OFS_FAULT     = 8'h0F;        // Last fault code
  localparam logic [7:0] ADC_OFS_RESTART   = 8'h10;        // Software restart
  localparam logic [7:0] ADC_OFS_PLAY      = 8'h13;        // Playback request
  localparam logic [7:0] ADC_OFS_MUTE      = 8'h14;        // Silence request
  localparam logic [7:0] ADC_OFS_ANCCMD    = 8'h16;        // Ancillary load command
  localparam logic [7:0] ADC_OFS_PINFN     = 8'h18;        // Shared pin function
  localparam logic [7:0] ADC_OFS_LOCK      = 8'h40;        // Frame lock state
  localparam logic [7:0] ADC_OFS_ANCLO     = 8'h41;        // Ancillary bits low
  localparam logic [7:0] ADC_OFS_ANCHI     = 8'h42;        // Ancillary bits high
  localparam logic [7:0] ADC_OFS_ANCBUF0   = 8'h59;        // First ancillary buffer byte
  localparam logic [7:0] ADC_OFS_ANCBUF4   = 8'h5D;        // Last ancillary buffer byte
  localparam int         ADC_ANC_BYTES     = 5;            // Ancillary buffer length
  // Reset values
  localparam logic [7:0] ADC_RST_CLKCTL    = 8'h21;
  localparam logic [7:0] ADC_RST_PLLM      = 8'h0C;
  localparam logic [7:0] ADC_RST_PLLN      = 8'h00;
  localparam logic [7:0] ADC_RST_REQPOL    = 8'h01;
  localparam logic [7:0] ADC_RST_CLKPOL    = 8'h04;
  localparam logic [7:0] ADC_RST_PLAY      = 8'h01;
  localparam logic [7:0] ADC_RST_ZERO      = 8'h00;
  // Clock control field positions
  localparam int ADC_CC_LOAD_FRAC  = 0;
  localparam int ADC_CC_XTAL_OUTDIV = 1;
  localparam int ADC_CC_XTAL_SYSDIV = 2;
  localparam int ADC_CC_OSC_OFF    = 3;
  localparam int ADC_CC_SYS_ON_PIN = 4;
  localparam int ADC_CC_CLKPAD_ON  = 5;
  localparam int ADC_CC_XOPAD_OFF  = 6;
  localparam int ADC_CC_SHPIN_ON   = 7;
  localparam int ADC_POL_BIT       = 2;                    // Polarity and pin-function select bit
  // Fault codes
  localparam logic [7:0] ADC_FAULT_NONE    = 8'h00;
  localparam logic [7:0] ADC_FAULT_CRC     = 8'h01;
  localparam logic [7:0] ADC_FAULT_NODATA  = 8'h02;
  localparam logic [3:0] ADC_FAULT_MASK    = 4'hF;         // Low nibble significant
  // Frame lock codes
  localparam logic [1:0] ADC_LOCK_SEARCH   = 2'h0;
  localparam logic [1:0] ADC_LOCK_CONFIRM  = 2'h1;
  localparam logic [1:0] ADC_LOCK_SYNCED   = 2'h2;
endpackage

// ### rtl/adc_if.sv
// Interface: two-wire control bus between host and decoder register bank
`timescale 1ns/100ps
interface adc_if;
  logic scl_o;         // Clock driven by host
  logic scl_oe;        // Host clock enable (line follows scl_o when set, high when clear)
  logic sda_host_oe;   // Host pulls data low
  logic sda_dev_oe;    // Device pulls data low
  wire  scl;           // Resolved clock line
  wire  sda;           // Resolved data line
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = ~(sda_host_oe | sda_dev_oe);
  modport host (output scl_o, output scl_oe, output sda_host_oe, input scl, input sda);
  modport dev  (output sda_dev_oe, input scl, input sda);
endinterface

// ### rtl/adc_dev.sv
// Device end: two-wire slave with the decoder control and status register bank
`timescale 1ns/100ps
// Functional notes
// - Host avoids undocumented reserved locations.
// - Host never writes read-only registers.
// - Fixed identifier register always reads same.
// - Clock bit0 loads fractional divider setting.
// - Clock bit1 feeds crystal to divider X.
// - Clock bit2 feeds crystal to divider S.
// - Clock bit3 disables oscillator output.
// - Clock bit4 puts system clock on pin.
// - Clock bit5 enables output clock pad.
// - Clock bit6 disables crystal output pad.
// - Clock bit7 enables shared clock/request pin.
// - Multiplier and divider managed by firmware.
// - Request polarity bit2 inverts data request.
// - Clock polarity bit2 swaps sampling edge.
// - Fault code holds most recent error.
// - Restart write clears commands, decoder idles.
// - Play applies only in decode state.
// - Mute keeps output clocks running.
// - Nonzero command loads five ancillary bytes.
// - Pin function bit2 picks clock or request.
// - Lock state reported in two bits.
// - Ancillary bit count split low/high bytes.
// - Address counter increments every data byte.
module adc_dev #(
  parameter logic [7:0] VERSION_VAL = 8'h11,  // Arbitrary version value
  parameter logic [7:0] IDENT_VAL   = 8'h5A   // Arbitrary identifier value
) (
  input  wire logic        ref_clk_i,          // Register clock
  input  wire logic        rst_i,              // Async reset, active high
  adc_if.dev               bus,                // Two-wire control bus
  input  wire logic        decoding_i,         // Decoder in decode state
  input  wire logic [1:0]  lock_state_i,       // Frame lock code from decoder
  input  wire logic        frame_ok_i,         // Pulse: frame decoded correctly
  input  wire logic [15:0] anc_bits_i,         // Ancillary bits in that frame
  input  wire logic        crc_fail_i,         // Pulse: CRC failure
  input  wire logic        no_data_i,          // Pulse: data not available
  input  wire logic        anc_valid_i,        // Ancillary byte stream valid
  input  wire logic [7:0]  anc_byte_i,         // Ancillary byte
  output logic             anc_ready_o,        // Take ancillary byte
  output logic             load_fraction_bit_o,
  output logic             crystal_to_out_divider_o,
  output logic             crystal_to_system_divider_o,
  output logic             oscillator_off_bit_o,
  output logic             system_freq_on_clock_pin_o,
  output logic             clock_out_pad_on_o,
  output logic             crystal_out_pad_off_o,
  output logic             shared_pin_on_o,
  output logic [7:0]       pll_mult_o,         // Firmware-managed multiplier
  output logic [7:0]       pll_div_o,          // Firmware-managed divider
  output logic             req_active_low_o,   // Data request active low
  output logic             sample_falling_o,   // Serial input sampled on falling edge
  output logic             shared_pin_is_req_o,// Shared pin carries data request
  output logic             play_o,             // Playback active
  output logic             mute_o,             // Muted (clocks keep running)
  output logic             decoder_idle_o      // Pulse: soft restart to idle
);
  typedef enum logic [2:0] {ST_IDLE, ST_DEVADR, ST_SUBADR, ST_WDATA, ST_RDATA, ST_ACK, ST_RACK} adc_st_e;

  // Synchronisers
  logic [1:0] scl_sy_ff, sda_sy_ff;
  logic       scl_d_ff, sda_d_ff;
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_sy_ff <= 2'b11;
      sda_sy_ff <= 2'b11;
      scl_d_ff  <= 1'b1;
      sda_d_ff  <= 1'b1;
    end
    else
    begin
      scl_sy_ff <= {scl_sy_ff[0], bus.scl};
      sda_sy_ff <= {sda_sy_ff[0], bus.sda};
      scl_d_ff  <= scl_sy_ff[1];
      sda_d_ff  <= sda_sy_ff[1];
    end
  end
  wire scl_s  = scl_sy_ff[1];
  wire sda_s  = sda_sy_ff[1];
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_c  = scl_s & scl_d_ff & ~sda_s & sda_d_ff;
  wire stop_c   = scl_s & scl_d_ff & sda_s & ~sda_d_ff;

  // Protocol engine state
  adc_st_e    st_ff, ret_ff;
  logic [7:0] sh_ff;                  // Shift register
  logic [3:0] bit_ff;                 // Bit count
  logic [7:0] adr_ff;                 // Register address counter
  logic       rd_ff;                  // Read transfer
  logic       sda_oe_ff;              // Pull data low
  logic       wr_stb_ff;              // One-cycle register write
  logic [7:0] wr_data_ff;
  logic [7:0] rdata;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_ff <= ST_IDLE; ret_ff <= ST_IDLE; sh_ff <= 8'h00; bit_ff <= 4'h0;
      adr_ff <= 8'h00; rd_ff <= 1'b0; sda_oe_ff <= 1'b0; wr_stb_ff <= 1'b0; wr_data_ff <= 8'h00;
    end
    else
    begin
      wr_stb_ff <= 1'b0;
      if (start_c)
      begin
        // Start or repeated start: expect device address
        st_ff <= ST_DEVADR; bit_ff <= 4'h0; sda_oe_ff <= 1'b0;
      end
      else if (stop_c)
      begin
        st_ff <= ST_IDLE; sda_oe_ff <= 1'b0;
      end
      else
      begin
        case (st_ff)
          ST_DEVADR, ST_SUBADR, ST_WDATA:
            if (scl_rise)
            begin
              sh_ff  <= {sh_ff[6:0], sda_s};
              bit_ff <= bit_ff + 4'h1;
            end
            else if (scl_fall && bit_ff == 4'h8)
            begin
              bit_ff <= 4'h0;
              ret_ff <= st_ff;
              if (st_ff == ST_DEVADR)
              begin
                if (sh_ff[7:1] == adc_pkg::ADC_DEV_ADDR)
                begin
                  rd_ff <= sh_ff[0]; sda_oe_ff <= 1'b1; st_ff <= ST_ACK;
                end
                else
                  st_ff <= ST_IDLE;
              end
              else if (st_ff == ST_SUBADR)
              begin
                adr_ff <= sh_ff; sda_oe_ff <= 1'b1; st_ff <= ST_ACK;
              end
              else
              begin
                wr_stb_ff <= 1'b1; wr_data_ff <= sh_ff; sda_oe_ff <= 1'b1; st_ff <= ST_ACK;
              end
            end
          ST_ACK:
            if (scl_fall)
            begin
              sda_oe_ff <= 1'b0;
              if (ret_ff == ST_DEVADR && rd_ff)
              begin
                sh_ff <= rdata; st_ff <= ST_RDATA; sda_oe_ff <= ~rdata[7];
                adr_ff <= adr_ff + 8'h01;
              end
              else if (ret_ff == ST_DEVADR)
                st_ff <= ST_SUBADR;
              else
              begin
                st_ff <= ST_WDATA;
                if (ret_ff == ST_WDATA)
                  adr_ff <= adr_ff + 8'h01;
              end
            end
          ST_RDATA:
            if (scl_fall)
            begin
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == 4'h7)
              begin
                sda_oe_ff <= 1'b0; st_ff <= ST_RACK; bit_ff <= 4'h0;
              end
              else
              begin
                sh_ff <= {sh_ff[6:0], 1'b0}; sda_oe_ff <= ~sh_ff[6];
              end
            end
          ST_RACK:
            if (scl_rise && sda_s)
              st_ff <= ST_IDLE;                      // Host not acknowledging: end
            else if (scl_fall)
            begin
              sh_ff <= rdata; sda_oe_ff <= ~rdata[7]; st_ff <= ST_RDATA;
              adr_ff <= adr_ff + 8'h01;
            end
          default: st_ff <= ST_IDLE;
        endcase
      end
    end
  end
  assign bus.sda_dev_oe = sda_oe_ff;

  // Register bank
  logic [7:0]  clkctl_ff, pllm_ff, plln_ff, fault_ff;
  logic        reqpol_ff, clkpol_ff, play_ff, mute_ff, pinfn_ff, anccmd_ff;
  logic [15:0] anccnt_ff;
  logic [7:0]  ancbuf_ff [adc_pkg::ADC_ANC_BYTES];
  logic [2:0]  ancidx_ff;
  wire         soft_rst = wr_stb_ff && adr_ff == adc_pkg::ADC_OFS_RESTART;
  wire         wr_en    = wr_stb_ff;

  // Control registers written by host
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clkctl_ff <= adc_pkg::ADC_RST_CLKCTL; pllm_ff <= adc_pkg::ADC_RST_PLLM; plln_ff <= adc_pkg::ADC_RST_PLLN;
      reqpol_ff <= 1'b0; clkpol_ff <= 1'b1; play_ff <= 1'b1; mute_ff <= 1'b0; pinfn_ff <= 1'b0;
    end
    else if (wr_en)
    begin
      case (adr_ff)
        adc_pkg::ADC_OFS_CLKCTL: clkctl_ff <= wr_data_ff;
        adc_pkg::ADC_OFS_PLLM:   pllm_ff   <= wr_data_ff;
        adc_pkg::ADC_OFS_PLLN:   plln_ff   <= wr_data_ff;
        adc_pkg::ADC_OFS_REQPOL: reqpol_ff <= wr_data_ff[adc_pkg::ADC_POL_BIT];
        adc_pkg::ADC_OFS_CLKPOL: clkpol_ff <= wr_data_ff[adc_pkg::ADC_POL_BIT];
        adc_pkg::ADC_OFS_PLAY:   play_ff   <= wr_data_ff[0];
        adc_pkg::ADC_OFS_MUTE:   mute_ff   <= wr_data_ff[0];
        adc_pkg::ADC_OFS_PINFN:  pinfn_ff  <= wr_data_ff[adc_pkg::ADC_POL_BIT];
        default: ;
      endcase
    end
  end

  // Ancillary load command and buffer fill; soft restart clears the command
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      anccmd_ff <= 1'b0; ancidx_ff <= 3'd0;
      for (int i = 0; i < adc_pkg::ADC_ANC_BYTES; i++) ancbuf_ff[i] <= 8'h00;
    end
    else if (soft_rst)
    begin
      anccmd_ff <= 1'b0; ancidx_ff <= 3'd0;
    end
    else if (wr_en && adr_ff == adc_pkg::ADC_OFS_ANCCMD && wr_data_ff != 8'h00)
    begin
      anccmd_ff <= 1'b1; ancidx_ff <= 3'd0;
    end
    else if (anccmd_ff && anc_valid_i)
    begin
      ancbuf_ff[ancidx_ff] <= anc_byte_i;
      ancidx_ff <= ancidx_ff + 3'd1;
      if (ancidx_ff == 3'(adc_pkg::ADC_ANC_BYTES - 1))
        anccmd_ff <= 1'b0;
    end
  end
  assign anc_ready_o = anccmd_ff;

  // Status captured from decoder
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fault_ff <= adc_pkg::ADC_FAULT_NONE; anccnt_ff <= 16'h0000;
    end
    else
    begin
      // Restart clears first; an event in the same cycle still wins
      if (soft_rst)
      begin
        fault_ff <= adc_pkg::ADC_FAULT_NONE; anccnt_ff <= 16'h0000;
      end
      if (crc_fail_i)
        fault_ff <= adc_pkg::ADC_FAULT_CRC;
      else if (no_data_i)
        fault_ff <= adc_pkg::ADC_FAULT_NODATA;
      if (frame_ok_i)
        anccnt_ff <= anc_bits_i;
    end
  end

  // Read multiplexer; unmapped and write-only read zero
  always_comb
  begin
    rdata = 8'h00;
    case (adr_ff)
      adc_pkg::ADC_OFS_VERSION: rdata = VERSION_VAL;
      adc_pkg::ADC_OFS_IDENT:   rdata = IDENT_VAL;
      adc_pkg::ADC_OFS_CLKCTL:  rdata = clkctl_ff;
      adc_pkg::ADC_OFS_PLLM:    rdata = pllm_ff;
      adc_pkg::ADC_OFS_PLLN:    rdata = plln_ff;
      adc_pkg::ADC_OFS_REQPOL:  rdata = {5'h00, reqpol_ff, 2'b01};
      adc_pkg::ADC_OFS_CLKPOL:  rdata = {5'h00, clkpol_ff, 2'b00};
      adc_pkg::ADC_OFS_FAULT:   rdata = {4'h0, fault_ff[3:0] & adc_pkg::ADC_FAULT_MASK};
      adc_pkg::ADC_OFS_PLAY:    rdata = {7'h00, play_ff};
      adc_pkg::ADC_OFS_MUTE:    rdata = {7'h00, mute_ff};
      adc_pkg::ADC_OFS_ANCCMD:  rdata = {7'h00, anccmd_ff};
      adc_pkg::ADC_OFS_PINFN:   rdata = {5'h00, pinfn_ff, 2'b00};
      adc_pkg::ADC_OFS_LOCK:    rdata = {6'h00, lock_state_i};
      adc_pkg::ADC_OFS_ANCLO:   rdata = anccnt_ff[7:0];
      adc_pkg::ADC_OFS_ANCHI:   rdata = anccnt_ff[15:8];
      default:
        if (adr_ff >= adc_pkg::ADC_OFS_ANCBUF0 && adr_ff <= adc_pkg::ADC_OFS_ANCBUF4)
          rdata = ancbuf_ff[3'(adr_ff - adc_pkg::ADC_OFS_ANCBUF0)];
    endcase
  end

  // Registered control outputs
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {shared_pin_on_o, crystal_out_pad_off_o, clock_out_pad_on_o, system_freq_on_clock_pin_o,
       oscillator_off_bit_o, crystal_to_system_divider_o, crystal_to_out_divider_o,
       load_fraction_bit_o} <= adc_pkg::ADC_RST_CLKCTL;
      pll_mult_o <= adc_pkg::ADC_RST_PLLM; pll_div_o <= adc_pkg::ADC_RST_PLLN;
      req_active_low_o <= 1'b0; sample_falling_o <= 1'b1; shared_pin_is_req_o <= 1'b0;
      play_o <= 1'b0; mute_o <= 1'b0; decoder_idle_o <= 1'b0;
    end
    else
    begin
      load_fraction_bit_o         <= clkctl_ff[adc_pkg::ADC_CC_LOAD_FRAC];
      crystal_to_out_divider_o    <= clkctl_ff[adc_pkg::ADC_CC_XTAL_OUTDIV];
      crystal_to_system_divider_o <= clkctl_ff[adc_pkg::ADC_CC_XTAL_SYSDIV];
      oscillator_off_bit_o        <= clkctl_ff[adc_pkg::ADC_CC_OSC_OFF];
      system_freq_on_clock_pin_o  <= clkctl_ff[adc_pkg::ADC_CC_SYS_ON_PIN];
      clock_out_pad_on_o          <= clkctl_ff[adc_pkg::ADC_CC_CLKPAD_ON];
      crystal_out_pad_off_o       <= clkctl_ff[adc_pkg::ADC_CC_XOPAD_OFF];
      shared_pin_on_o             <= clkctl_ff[adc_pkg::ADC_CC_SHPIN_ON];
      pll_mult_o <= pllm_ff;
      pll_div_o  <= plln_ff;
      req_active_low_o    <= reqpol_ff;
      sample_falling_o    <= clkpol_ff;
      shared_pin_is_req_o <= pinfn_ff;
      play_o         <= play_ff & decoding_i;
      mute_o         <= mute_ff;
      decoder_idle_o <= soft_rst;
    end
  end
endmodule

// ### rtl/adc_host.sv
// Host end: two-wire master issuing single register reads and writes
`timescale 1ns/100ps
module adc_host #(
  parameter int HALF_BIT = 5                          // Clock cycles per quarter bus clock
) (
  input  wire logic       ref_clk_i,                  // Clock
  input  wire logic       rst_i,                      // Async reset, active high
  adc_if.host             bus,                        // Two-wire control bus
  input  wire logic       req_i,                      // Start a transfer (pulse)
  input  wire logic       rd_i,                       // 1 read, 0 write
  input  wire logic [7:0] addr_i,                     // Register address
  input  wire logic [7:0] wdata_i,                    // Write data
  output logic            busy_o,                     // Transfer running
  output logic            done_o,                     // Pulse: transfer done
  output logic [7:0]      rdata_o,                    // Read data
  output logic            nack_o                      // Device did not acknowledge
);
  initial if (HALF_BIT < 4) $error("HALF_BIT too small");
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_DONE} adc_hst_e;
  adc_hst_e    st_ff;
  logic [15:0] div_ff;
  logic [7:0]  ph_ff;                                 // Quarter step: slot in [7:2], quarter in [1:0]
  logic [35:0] seq_ff;                                // Data bits to send
  logic [1:0]  sda_sy_ff;
  logic        scl_ff, sda_oe_ff, rd_ff;
  logic [7:0]  rx_ff;
  wire         tick = div_ff == 16'(HALF_BIT - 1);
  wire [5:0]   slot      = ph_ff[7:2];                // Bit slot of the transfer
  wire [5:0]   ack_slot  = rd_ff ? 6'd27 : 6'd26;     // Last acknowledge from the device
  wire [5:0]   stop_slot = rd_ff ? 6'd37 : 6'd27;     // Slot that carries the stop
  // Bus phases: write = S dev A sub A data A P; read = S dev A sub A Sr dev+1 A data N P
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i) sda_sy_ff <= 2'b11;
    else       sda_sy_ff <= {sda_sy_ff[0], bus.sda};
  end
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_ff <= H_IDLE; div_ff <= 16'h0000; ph_ff <= 8'h00; seq_ff <= '0; scl_ff <= 1'b1;
      sda_oe_ff <= 1'b0; rd_ff <= 1'b0; rx_ff <= 8'h00; busy_o <= 1'b0; done_o <= 1'b0;
      rdata_o <= 8'h00; nack_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (st_ff)
        H_IDLE:
          if (req_i)
          begin
            rd_ff <= rd_i; busy_o <= 1'b1; nack_o <= 1'b0; ph_ff <= 8'h00; div_ff <= 16'h0000;
            seq_ff <= {adc_pkg::ADC_DEV_ADDR, 1'b0, 1'b1, addr_i, 1'b1,
                       rd_i ? {adc_pkg::ADC_DEV_ADDR, 1'b1, 1'b1, 8'hFF, 1'b1} : {wdata_i, 1'b1, 9'h1FF}};
            sda_oe_ff <= 1'b1;                       // Start: data low while clock high
            st_ff <= H_RUN;
          end
        H_RUN:
        begin
          div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
          if (tick)
          begin
            ph_ff <= ph_ff + 8'd1;
            // Data moves a quarter after the clock falls and is sampled a quarter after it rises,
            // so the device's synchronised answer is settled and start/stop never coincide with a clock edge
            case (ph_ff[1:0])
              2'd0: scl_ff <= 1'b0;                  // Clock falls
              2'd1:
                if (slot == stop_slot)
                  sda_oe_ff <= 1'b1;                 // Data low ahead of the stop
                else if (rd_ff && slot == 6'd18)
                  sda_oe_ff <= 1'b0;                 // Data high ahead of the repeated start
                else
                begin
                  sda_oe_ff <= ~seq_ff[35];          // Next bit, MSB first
                  seq_ff    <= {seq_ff[34:0], 1'b1};
                end
              2'd2: scl_ff <= 1'b1;                  // Clock rises
              default:
                if (slot == stop_slot)
                begin
                  sda_oe_ff <= 1'b0;                 // Stop: data rises while clock high
                  st_ff     <= H_DONE;
                end
                else if (rd_ff && slot == 6'd18)
                  sda_oe_ff <= 1'b1;                 // Repeated start: data falls while clock high
                else
                begin
                  if ((slot == 6'd8 || slot == 6'd17 || slot == ack_slot) && sda_sy_ff[1])
                    nack_o <= 1'b1;                  // No acknowledge from the device
                  if (rd_ff && slot >= 6'd28 && slot <= 6'd35)
                    rx_ff <= {rx_ff[6:0], sda_sy_ff[1]};
                end
            endcase
          end
        end
        H_DONE:
        begin
          busy_o <= 1'b0; done_o <= 1'b1; rdata_o <= rx_ff; st_ff <= H_IDLE;
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end
  assign bus.scl_o       = scl_ff;
  assign bus.scl_oe      = 1'b1;
  assign bus.sda_host_oe = sda_oe_ff;
endmodule

// ### bench/adc_assertions.sv
// Checker: wire-level timing of the two-wire bus between host and device ends
`timescale 1ns/100ps
module adc_assertions (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  AST_DEV_HOLD: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device data moved while clock high");
  AST_NO_FIGHT: assert property (sda_dev_oe && scl |-> !sda_host_oe)
    else $error("both ends drive data");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*4])
    else $error("clock low phase too short");
  AST_IDLE: assert property ($fell(rst_i) |-> scl && sda)
    else $error("bus not idle after reset");
  AST_DEV_RELEASE: assert property ($rose(sda_dev_oe) |-> ##[1:200] !sda_dev_oe)
    else $error("device holds data line");
  AST_START_HOST: assert property ($fell(sda) && scl && $past(scl) |-> !sda_dev_oe)
    else $error("device made a start");
  AST_STOP_HOST: assert property ($rose(sda) && scl && $past(scl) |-> !$past(sda_dev_oe))
    else $error("device made a stop");
endmodule

// ### bench/audio_decoder_control_registers_tb.sv
// Testbench: host and device ends joined, register bank checked through the host end
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module audio_decoder_control_registers_tb;
  logic        ref_clk_i = 1'b0;                     // Bench clock
  logic        rst_i = 1'b1;                         // Reset
  logic        req, rd, done, nack, dec, frm, crc, nod, idle, ral, sf, spr, play, mute, av, ardy;
  logic [7:0]  anc [5];                              // Ancillary bytes fed to the device
  logic        seen = 1'b0;                          // Restart pulse seen
  logic [7:0]  addr, wdata, rdata, v, cc, ab, pm;    // cc: clock control outputs
  logic [1:0]  lock;                                 // Frame lock code
  logic [15:0] bits;                                 // Ancillary bit count
  int          n_errors = 0, tests_run = 0, k;
  adc_if bus ();
  adc_host u_adc_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus), .req_i(req), .rd_i(rd), .addr_i(addr),
    .wdata_i(wdata), .busy_o(), .done_o(done), .rdata_o(rdata), .nack_o(nack));
  adc_dev u_adc_dev (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus), .decoding_i(dec), .lock_state_i(lock),
    .frame_ok_i(frm), .anc_bits_i(bits), .crc_fail_i(crc), .no_data_i(nod), .anc_valid_i(av), .anc_byte_i(ab),
    .anc_ready_o(ardy), .load_fraction_bit_o(cc[0]), .crystal_to_out_divider_o(cc[1]), .crystal_to_system_divider_o(cc[2]),
    .oscillator_off_bit_o(cc[3]), .system_freq_on_clock_pin_o(cc[4]), .clock_out_pad_on_o(cc[5]),
    .crystal_out_pad_off_o(cc[6]), .shared_pin_on_o(cc[7]), .pll_mult_o(pm), .pll_div_o(), .req_active_low_o(ral),
    .sample_falling_o(sf), .shared_pin_is_req_o(spr), .play_o(play), .mute_o(mute), .decoder_idle_o(idle));
  adc_assertions u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl(bus.scl), .sda(bus.sda),
    .sda_host_oe(bus.sda_host_oe), .sda_dev_oe(bus.sda_dev_oe));
  always #50 ref_clk_i = ~ref_clk_i;
  // Latch the one-cycle restart pulse
  always @(posedge ref_clk_i) if (idle === 1'b1) seen <= 1'b1;
  // One register transfer, bounded wait on done
  task automatic xfer(input logic r_w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk_i) #1;
    {req, rd, addr, wdata} = {1'b1, r_w, a, d};
    @(posedge ref_clk_i) #1;
    req = 1'b0;
    for (n = 0; n < 2000 && done !== 1'b1; n++) @(posedge ref_clk_i) #1;
    if (n == 2000)
    begin
      n_errors++;
      $display("[FAIL] %0t transfer timed out", $time);
      end_of_test();
    end
    `CHK(nack, 1'b0)
  endtask
  // Read and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    `CHK(rdata, e)
  endtask
  // Verdict
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #6_000_000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
  initial
  begin
    {req, rd, addr, wdata, dec, lock, frm, bits, crc, nod, av, ab} = '0;
    v = $urandom(32'hcc8a_b8a1);
    repeat (3) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    `CHK(cc, 8'h21)
    `CHK(pm, 8'h0C)
    rchk(8'h01, 8'h5A);
    rchk(8'h05, 8'h21);
    rchk(8'h0C, 8'h01);
    rchk(8'h0D, 8'h04);
    rchk(8'h06, 8'h0C);
    `CHK(play, 1'b0)
    repeat (4)
    begin
      v = $urandom;
      xfer(1'b0, 8'h05, v);
      `CHK(cc, v)
      rchk(8'h05, v);
    end
    $display("clock control done");
    rchk(8'h01, 8'h5A);
    xfer(1'b0, 8'h0C, 8'h05);
    `CHK(ral, 1'b1)
    xfer(1'b0, 8'h0D, 8'hFB);
    `CHK(sf, 1'b0)
    rchk(8'h0D, 8'h00);
    xfer(1'b0, 8'h18, 8'h04);
    `CHK(spr, 1'b1)
    dec = 1'b1;
    xfer(1'b0, 8'h13, 8'h01);
    `CHK(play, 1'b1)
    xfer(1'b0, 8'h14, 8'h01);
    `CHK(mute, 1'b1)
    @(posedge ref_clk_i) #1 crc = 1'b1;
    @(posedge ref_clk_i) #1 crc = 1'b0;
    rchk(8'h0F, 8'h01);
    @(posedge ref_clk_i) #1 nod = 1'b1;
    @(posedge ref_clk_i) #1 nod = 1'b0;
    rchk(8'h0F, 8'h02);
    xfer(1'b0, 8'h16, 8'h01);
    rchk(8'h16, 8'h01);
    xfer(1'b0, 8'h10, v);
    `CHK(seen, 1'b1)
    rchk(8'h16, 8'h00);
    rchk(8'h0F, 8'h00);
    xfer(1'b0, 8'h16, 8'h01);
    `CHK(ardy, 1'b1)
    for (k = 0; k < 5; k++)
    begin
      anc[k] = 8'($urandom);
      @(posedge ref_clk_i) #1 {av, ab} = {1'b1, anc[k]};
    end
    @(posedge ref_clk_i) #1 av = 1'b0;
    for (k = 0; k < 5; k++)
      rchk(8'h59 + 8'(k), anc[k]);
    rchk(8'h16, 8'h00);
    $display("commands done");
    for (k = 0; k < 3; k++)
    begin
      lock = k[1:0];
      rchk(8'h40, {6'h00, lock});
    end
    bits = $urandom;
    @(posedge ref_clk_i) #1 frm = 1'b1;
    @(posedge ref_clk_i) #1 frm = 1'b0;
    rchk(8'h41, bits[7:0]);
    rchk(8'h42, bits[15:8]);
    $display("status done");
    end_of_test();
  end
endmodule
